// [verilog/tmk_time_keeper.sv]
// Time-of-day keeper with staging, load, snapshot and drift adjustment registers.
//
// Overview of operation
// - 32-bit staging register holds seconds or interval.
// - Control bit 0 loads staging into seconds.
// - Control bit 2 loads staging into interval.
// - Control bit 1 snapshots full 64-bit time.
// - Bit 4 enables drift adjustment, else plain counting.
// - Expiry steps by two, or skips, per bit 5.
// - Interval readable as 24-bit read-only register.
// - Control register eight bits, bits 7-6, 3 reserved.
// - Snapshot: seconds high, fraction 31-12, low zero.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
module tmk_time_keeper (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] elapsed_seconds,
    output logic [19:0] elapsed_fraction
);
    tmk_regbus_if rb ();

    logic [31:0] stage_q;
    logic [23:0] drift_interval_value_q;
    logic [23:0] adj_cnt_q;
    logic [23:0] adj_cnt_d;
    logic [31:0] sec_q;
    logic [31:0] sec_d;
    logic [19:0] frac_q;
    logic [19:0] frac_d;
    logic [63:0] time_snapshot_reg_q;
    logic adj_en_q;
    logic adj_plus_q;
    logic frac_tick;
    logic ctl_wr;
    logic stage_wr;
    logic load_seconds_strobe;
    logic snapshot_strobe;
    logic load_interval_strobe;
    logic adj_expire;
    logic [1:0] frac_step;
    logic [20:0] frac_sum;
    logic frac_carry;
    logic [7:0] ctrl_rd;
    logic [63:0] time_now;

    tmk_axil_slave u_bus (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rb(rb)
    );

    tmk_frac_tick u_tick (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .tick(frac_tick)
    );

    // Write decoding; the control register lives in byte lane 0.
    assign stage_wr = rb.wr_en & (rb.wr_idx == tmk_pkg::IDX_STAGE);
    assign ctl_wr = rb.wr_en & (rb.wr_idx == tmk_pkg::IDX_CTRL) & rb.wr_strb[0];
    assign load_seconds_strobe = ctl_wr & rb.wr_data[tmk_pkg::CTL_LOAD_SEC];
    assign snapshot_strobe = ctl_wr & rb.wr_data[tmk_pkg::CTL_SNAP];
    assign load_interval_strobe = ctl_wr & rb.wr_data[tmk_pkg::CTL_LOAD_ADJ];
    assign rb.wr_ok = (rb.wr_idx == tmk_pkg::IDX_STAGE) | (rb.wr_idx == tmk_pkg::IDX_CTRL);

    // Drift timer counts fraction ticks; an interval of zero never expires.
    assign adj_expire = frac_tick & adj_en_q & (drift_interval_value_q != 24'h00_0000)
        & (24'(adj_cnt_q + 24'h00_0001) == drift_interval_value_q);
    assign frac_step = adj_expire ? (adj_plus_q ? 2'h2 : 2'h0) : 2'h1;
    assign frac_sum = {1'b0, frac_q} + {19'h0_0000, frac_step};
    assign frac_carry = frac_tick & frac_sum[20];
    assign frac_d = frac_tick ? frac_sum[19:0] : frac_q;
    // A seconds load wins over a carry landing in the same cycle.
    assign sec_d = load_seconds_strobe ? stage_q : (frac_carry ? 32'(sec_q + 32'h0000_0001) : sec_q);
    assign adj_cnt_d = (load_interval_strobe | adj_expire | ~adj_en_q) ? 24'h00_0000
        : (frac_tick ? 24'(adj_cnt_q + 24'h00_0001) : adj_cnt_q);

    // The snapshot view pads fraction into the upper 20 bits of the low word.
    assign time_now = {sec_q, frac_q, 12'h000};
    assign ctrl_rd = {2'h0, adj_plus_q, adj_en_q, 1'h0, 3'h0};

    // Read decoding.
    assign rb.rd_ok = (rb.rd_idx == tmk_pkg::IDX_SNAP_LO) | (rb.rd_idx == tmk_pkg::IDX_SNAP_HI)
        | (rb.rd_idx == tmk_pkg::IDX_STAGE) | (rb.rd_idx == tmk_pkg::IDX_ADJ) | (rb.rd_idx == tmk_pkg::IDX_CTRL);
    assign rb.rd_data = (rb.rd_idx == tmk_pkg::IDX_SNAP_LO) ? time_snapshot_reg_q[31:0]
        : (rb.rd_idx == tmk_pkg::IDX_SNAP_HI) ? time_snapshot_reg_q[63:32]
        : (rb.rd_idx == tmk_pkg::IDX_STAGE) ? stage_q
        : (rb.rd_idx == tmk_pkg::IDX_ADJ) ? {8'h00, drift_interval_value_q}
        : (rb.rd_idx == tmk_pkg::IDX_CTRL) ? {24'h00_0000, ctrl_rd}
        : 32'h0000_0000;

    assign elapsed_seconds = sec_q;
    assign elapsed_fraction = frac_q;

    // Staging register honours byte strobes lane by lane.
    for (genvar b = 0; b < 4; b++) begin : g_stage
        always_ff @(posedge clk) begin
            if (!resetn) begin
                stage_q[8*b +: 8] <= tmk_pkg::STAGE_RST[8*b +: 8];
            end else if (ce && stage_wr && rb.wr_strb[b]) begin
                stage_q[8*b +: 8] <= rb.wr_data[8*b +: 8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sec_q <= tmk_pkg::SEC_RST;
            frac_q <= tmk_pkg::FRAC_RST;
            adj_cnt_q <= tmk_pkg::ADJ_RST;
        end else if (ce) begin
            sec_q <= sec_d;
            frac_q <= frac_d;
            adj_cnt_q <= adj_cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            drift_interval_value_q <= tmk_pkg::ADJ_RST;
        end else if (ce && load_interval_strobe) begin
            drift_interval_value_q <= stage_q[23:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            time_snapshot_reg_q <= 64'h0000_0000_0000_0000;
        end else if (ce && snapshot_strobe) begin
            time_snapshot_reg_q <= time_now;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            adj_en_q <= 1'b0;
            adj_plus_q <= 1'b0;
        end else if (ce && ctl_wr) begin
            adj_en_q <= rb.wr_data[tmk_pkg::CTL_ADJ_EN];
            adj_plus_q <= rb.wr_data[tmk_pkg::CTL_ADJ_PLUS];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_stage_full_write: assert property (
        stage_wr && rb.wr_strb == 4'hf
        |=> stage_q == $past(rb.wr_data)
    ) else $error("Staging register missed a full write.");

    a_seconds_load: assert property (
        load_seconds_strobe
        |=> sec_q == $past(stage_q)
    ) else $error("Seconds counter did not take the staging value.");

    a_interval_load: assert property (
        load_interval_strobe
        |=> drift_interval_value_q == $past(stage_q[23:0]) ##1 adj_cnt_q <= 24'h00_0001
    ) else $error("Interval value not loaded or timer not restarted.");

    a_snapshot_take: assert property (
        snapshot_strobe
        |=> time_snapshot_reg_q[63:32] == $past(sec_q) && time_snapshot_reg_q[31:12] == $past(frac_q)
    ) else $error("Snapshot does not hold the time of the capture.");

    a_plain_count: assert property (
        frac_tick && !adj_en_q
        |=> frac_q == 20'($past(frac_q) + 20'h0_0001)
    ) else $error("Fraction did not advance by one with adjustment off.");

    a_drift_plus: assert property (
        adj_expire && adj_plus_q
        |=> frac_q == 20'($past(frac_q) + 20'h0_0002)
    ) else $error("Plus adjustment did not add two.");

    a_drift_skip: assert property (
        adj_expire && !adj_plus_q
        |=> $stable(frac_q)
    ) else $error("Minus adjustment did not skip a step.");

    a_interval_read: assert property (
        rb.rd_idx == tmk_pkg::IDX_ADJ
        |-> rb.rd_data == {8'h00, drift_interval_value_q} && rb.rd_ok
    ) else $error("Interval readback differs from the held value.");

    a_ctrl_reserved: assert property (
        rb.rd_idx == tmk_pkg::IDX_CTRL
        |-> rb.rd_data[31:6] == 26'h000_0000 && rb.rd_data[3:0] == 4'h0
    ) else $error("Reserved or strobe control bits read non-zero.");

    a_snap_low_zero: assert property (
        rb.rd_idx == tmk_pkg::IDX_SNAP_LO
        |-> rb.rd_data[11:0] == 12'h000 && rb.rd_data[31:12] == time_snapshot_reg_q[31:12]
    ) else $error("Snapshot low word readback is wrong.");

    a_strobe_single: assert property (
        load_seconds_strobe
        |=> !load_seconds_strobe
    ) else $error("Seconds load strobe lasted more than one cycle.");

    a_adj_en_timer: assert property (
        !adj_en_q ##1 !adj_en_q
        |-> adj_cnt_q == 24'h00_0000 && !adj_expire
    ) else $error("Drift timer runs while adjustment is off.");

    a_stage_hold: assert property (
        !stage_wr
        |=> $stable(stage_q)
    ) else $error("Staging register changed without a write.");

    a_stage_lane_zero: assert property (
        stage_wr && rb.wr_strb == 4'h1
        |=> stage_q[31:8] == $past(stage_q[31:8]) && stage_q[7:0] == $past(rb.wr_data[7:0])
    ) else $error("Byte strobe write to staging touched the wrong lanes.");

    a_seconds_hold: assert property (
        !load_seconds_strobe && !frac_carry
        |=> $stable(sec_q)
    ) else $error("Seconds counter moved without a load or a carry.");

    a_interval_hold: assert property (
        !load_interval_strobe
        |=> $stable(drift_interval_value_q)
    ) else $error("Interval value changed without a load strobe.");

    a_snapshot_hold: assert property (
        !snapshot_strobe
        |=> $stable(time_snapshot_reg_q)
    ) else $error("Snapshot changed without a capture strobe.");

    a_enable_write: assert property (
        ctl_wr
        |=> adj_en_q == $past(rb.wr_data[tmk_pkg::CTL_ADJ_EN])
    ) else $error("Adjustment enable did not follow the control write.");

    a_frac_idle: assert property (
        !frac_tick
        |=> $stable(frac_q)
    ) else $error("Fraction moved between ticks.");

    a_plus_write: assert property (
        ctl_wr
        |=> adj_plus_q == $past(rb.wr_data[tmk_pkg::CTL_ADJ_PLUS])
    ) else $error("Adjustment direction did not follow the control write.");

    a_interval_read_only: assert property (
        rb.wr_en && rb.wr_idx == tmk_pkg::IDX_ADJ
        |-> !rb.wr_ok
    ) else $error("Write to the read-only interval was accepted.");

    a_ctrl_live_bits: assert property (
        rb.rd_idx == tmk_pkg::IDX_CTRL
        |-> rb.rd_data[5:4] == {adj_plus_q, adj_en_q}
    ) else $error("Control readback lost the enable or direction bit.");

    a_snap_high_read: assert property (
        rb.rd_idx == tmk_pkg::IDX_SNAP_HI
        |-> rb.rd_data == time_snapshot_reg_q[63:32]
    ) else $error("Snapshot high word readback differs from the held seconds.");

    a_snap_strobe_single: assert property (
        snapshot_strobe
        |=> !snapshot_strobe
    ) else $error("Snapshot strobe lasted more than one cycle.");

    c_seconds_load: cover property (load_seconds_strobe);
    c_snapshot: cover property (snapshot_strobe ##[1:20] rb.rd_idx == tmk_pkg::IDX_SNAP_HI);
    c_drift_plus: cover property (adj_expire && adj_plus_q);
    c_drift_skip: cover property (adj_expire && !adj_plus_q);
    c_second_wrap: cover property (frac_carry);

endmodule // tmk_time_keeper

// [inc/tmk_pkg.sv]
// Constants, register map and address decoding shared by the time keeper files.
package tmk_pkg;

    // Clock rate and fractional time base, one fraction step is 1/2^20 s.
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned FRAC_HZ = 1_048_576;
    localparam int unsigned ACC_W = 28;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(FRAC_HZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);

    // Field widths.
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned SEC_W = 32;
    localparam int unsigned FRAC_W = 20;
    localparam int unsigned ADJ_W = 24;
    localparam int unsigned PAD_W = 12;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_SNAP_LO = 8'h80;
    localparam logic [7:0] IDX_SNAP_HI = 8'h81;
    localparam logic [7:0] IDX_STAGE = 8'h88;
    localparam logic [7:0] IDX_ADJ = 8'h8c;
    localparam logic [7:0] IDX_CTRL = 8'h8f;

    // Time control bit positions.
    localparam int unsigned CTL_LOAD_SEC = 0;
    localparam int unsigned CTL_SNAP = 1;
    localparam int unsigned CTL_LOAD_ADJ = 2;
    localparam int unsigned CTL_ADJ_EN = 4;
    localparam int unsigned CTL_ADJ_PLUS = 5;

    // Reset values.
    localparam logic [31:0] STAGE_RST = 32'h0000_0000;
    localparam logic [23:0] ADJ_RST = 24'h00_0000;
    localparam logic [31:0] SEC_RST = 32'h0000_0000;
    localparam logic [19:0] FRAC_RST = 20'h0_0000;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [7:0] addr_idx(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:2];
    endfunction

endpackage

// [inc/tmk_regbus_if.sv]
// Register access carrier between the bus slave and the time keeper core.
`timescale 1ns/10ps
interface tmk_regbus_if;
    logic wr_en;
    logic [7:0] wr_idx;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [7:0] rd_idx;
    logic [31:0] rd_data;
    logic rd_ok;
    modport bus_end (output wr_en, wr_idx, wr_data, wr_strb, rd_idx, input wr_ok, rd_data, rd_ok);
    modport reg_end (input wr_en, wr_idx, wr_data, wr_strb, rd_idx, output wr_ok, rd_data, rd_ok);
endinterface

// [verilog/tmk_frac_tick.sv]
// Fraction tick generator: exact 2^20 ticks per second from the system clock.
`timescale 1ns/10ps
module tmk_frac_tick (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    output logic tick
);
    // A phase accumulator avoids the drift of a rounded integer divider.
    logic [tmk_pkg::ACC_W-1:0] acc_q;
    logic [tmk_pkg::ACC_W-1:0] acc_sum;
    logic [tmk_pkg::ACC_W-1:0] acc_d;
    assign acc_sum = acc_q + tmk_pkg::ACC_STEP;
    assign tick = ce & (acc_sum >= tmk_pkg::ACC_WRAP);
    assign acc_d = tick ? acc_sum - tmk_pkg::ACC_WRAP : acc_sum;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            acc_q <= '0;
        end else if (ce) begin
            acc_q <= acc_d;
        end
    end
endmodule // tmk_frac_tick

// [verilog/tmk_axil_slave.sv]
// AXI4-Lite slave front end feeding single-cycle register accesses.
`timescale 1ns/10ps
module tmk_axil_slave (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    tmk_regbus_if.bus_end rb
);
    logic aw_full_q;
    logic w_full_q;
    logic [9:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic do_wr;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;

    // Address and data are held apart so they may arrive in either order.
    assign s_axi_awready = ce & ~aw_full_q;
    assign s_axi_wready = ce & ~w_full_q;
    assign s_axi_arready = ce & ~rvalid_q;
    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign ar_hs = s_axi_arvalid & s_axi_arready;
    assign do_wr = ce & aw_full_q & w_full_q & ~bvalid_q;
    assign rb.wr_en = do_wr;
    assign rb.wr_idx = tmk_pkg::addr_idx(awaddr_q);
    assign rb.wr_data = wdata_q;
    assign rb.wr_strb = wstrb_q;
    assign rb.rd_idx = tmk_pkg::addr_idx(s_axi_araddr);
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 10'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= tmk_pkg::RESP_OKAY;
        end else if (ce) begin
            if (aw_hs) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_full_q <= 1'b0;
            end
            if (w_hs) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_wr) begin
                w_full_q <= 1'b0;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= rb.wr_ok ? tmk_pkg::RESP_OKAY : tmk_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= tmk_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= rb.rd_ok ? rb.rd_data : 32'h0000_0000;
                rresp_q <= rb.rd_ok ? tmk_pkg::RESP_OKAY : tmk_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
endmodule // tmk_axil_slave

// [verif/tmk_time_keeper_tb.sv]
// Self-checking testbench for the time keeper, driving its AXI4-Lite ports.
`timescale 1ns/10ps
module tmk_time_keeper_tb;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} tmk_rexp_t;
    localparam logic [9:0] A_LO = {tmk_pkg::IDX_SNAP_LO, 2'h0};
    localparam logic [9:0] A_HI = {tmk_pkg::IDX_SNAP_HI, 2'h0};
    localparam logic [9:0] A_STG = {tmk_pkg::IDX_STAGE, 2'h0};
    localparam logic [9:0] A_ADJ = {tmk_pkg::IDX_ADJ, 2'h0};
    localparam logic [9:0] A_CTL = {tmk_pkg::IDX_CTRL, 2'h0};
    localparam logic [9:0] A_BAD = 10'h100;
    localparam logic [1:0] OK = tmk_pkg::RESP_OKAY;
    localparam logic [1:0] ER = tmk_pkg::RESP_SLVERR;
    localparam logic [31:0] FULL = 32'hffff_ffff;
    logic clk = 1'b0;
    logic resetn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [9:0] awaddr, araddr;
    logic [31:0] wdata, rdata, last_rd, v, f0;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [31:0] elapsed_seconds;
    logic [19:0] elapsed_fraction;
    logic [31:0] seed = 32'h0000_000d;
    logic [9:0] ra[5] = '{A_LO, A_HI, A_STG, A_ADJ, A_CTL};
    logic [7:0] md[4] = '{8'h00, 8'h20, 8'h30, 8'h10};
    logic [31:0] lo[4] = '{32'h64, 32'h64, 32'h7c, 32'h4a};
    logic [31:0] hi[4] = '{32'h65, 32'h65, 32'h7f, 32'h4d};
    int fail_count = 0;
    int checks = 0;
    tmk_rexp_t rq[$];
    tmk_rexp_t re;
    logic [1:0] wq[$];

    tmk_time_keeper uut (.clk(clk), .resetn(resetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .elapsed_seconds(elapsed_seconds), .elapsed_fraction(elapsed_fraction));

    always #4 clk = ~clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic close_out();
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Address and data are offered together and each is released at the edge that takes it.
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit ad = 1'b0;
        bit wd = 1'b0;
        wq.push_back(er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(ad && wd && bvalid));
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] er);
        rq.push_back(tmk_rexp_t'{d, m, er});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask

    // Results are matched in order against the notes left by the bus tasks.
    always @(posedge clk) begin
        if (rvalid && rready) begin
            re = rq.pop_front();
            last_rd <= rdata;
            cmp_data(rdata & re.m, re.d & re.m);
            cmp_resp(rresp, re.r);
        end
        if (bvalid && bready) begin
            cmp_resp(bresp, wq.pop_front());
        end
    end

    initial begin
        repeat (80000) @(posedge clk);
        fail_count++;
        close_out();
    end

    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 10'h0;
        araddr = 10'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        foreach (ra[i]) rd(ra[i], 32'h0, FULL, OK);
        v = xs();
        wr(A_STG, v, 4'hf, OK);
        rd(A_STG, v, FULL, OK);
        wr(A_STG, ~v, 4'h1, OK);
        v = {v[31:8], ~v[7:0]};
        rd(A_STG, v, FULL, OK);
        wr(A_CTL, 32'h1, 4'h1, OK);
        cmp_data(elapsed_seconds, v);
        rd(A_CTL, 32'h0, FULL, OK);
        wr(A_CTL, 32'hffff_ffc8, 4'hf, OK);
        rd(A_CTL, 32'h0, FULL, OK);
        wr(A_CTL, 32'h30, 4'h1, OK);
        rd(A_CTL, 32'h30, FULL, OK);
        wr(A_CTL, 32'h2, 4'h1, OK);
        rd(A_HI, v, FULL, OK);
        rd(A_LO, 32'h0, 32'h0000_0fff, OK);
        @(posedge clk);
        // The live fraction may move on by one tick during the two reads.
        f0 = {12'h0, elapsed_fraction} - {12'h0, last_rd[31:12]};
        cmp_data((f0 < 32'h2) ? 32'h0 : f0, 32'h0);
        ce <= 1'b0;
        @(posedge clk);
        f0 = {12'h0, elapsed_fraction};
        repeat (300) @(posedge clk);
        cmp_data({12'h0, elapsed_fraction}, f0);
        ce <= 1'b1;
        wr(A_ADJ, xs(), 4'hf, ER);
        wr(A_LO, xs(), 4'hf, ER);
        wr(A_BAD, xs(), 4'hf, ER);
        rd(A_BAD, 32'h0, FULL, ER);
        wr(A_STG, 32'hab00_0004, 4'hf, OK);
        wr(A_CTL, 32'h4, 4'h1, OK);
        rd(A_ADJ, 32'h0000_0004, FULL, OK);
        cmp_data(elapsed_seconds, v);
        // Tick phase and timer residue leave each window a tolerance of a few steps.
        for (int i = 0; i < 4; i++) begin
            wr(A_CTL, {24'h0, md[i]}, 4'h1, OK);
            f0 = {12'h0, elapsed_fraction};
            repeat (12000) @(posedge clk);
            f0 = {12'h0, elapsed_fraction} - f0;
            cmp_data((f0 >= lo[i] && f0 <= hi[i]) ? lo[i] : f0, lo[i]);
        end
        rd(A_ADJ, 32'h0000_0004, FULL, OK);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(A_STG, 32'h0, FULL, OK);
        cmp_data(elapsed_seconds, 32'h0);
        close_out();
    end
endmodule // tmk_time_keeper_tb
